// [hdl/sdcd_decoder.sv]
// Command decoder front end of the DRAM device.
// Assumes pins come from the controller outside this clock domain.
`timescale 1ns/10ps
module sdcd_decoder #(
    parameter bit DENSITY_1G_UP = 1'b1
) (
    input  wire logic                       CLK,
    input  wire logic                       SYS_RST,
    input  wire sdcd_pkg::sdcd_pins_t       PINS,
    input  wire logic                       ON_DIE_TERMINATION_CTL,
    output sdcd_pkg::sdcd_dec_t             DEC,
    output logic                            DEC_VALID,
    output logic                            IN_SELF_REFRESH,
    output logic                            IN_POWER_DOWN,
    output logic                            TERMINATION_EN
);
    import sdcd_pkg::*;

    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    sdcd_pins_t meta_ff, pins_ff, nxt_meta, nxt_pins;
    logic       odt_meta_ff, odt_ff, nxt_odt_meta, nxt_odt;
    logic       cke_prev_ff, nxt_cke_prev;

    always_comb begin
        nxt_meta         = PINS;
        nxt_pins         = meta_ff;
        nxt_odt_meta     = ON_DIE_TERMINATION_CTL;
        nxt_odt          = odt_meta_ff;
        nxt_cke_prev     = pins_ff.clk_en;
        if (SYS_RST) begin
            nxt_meta         = PINS_IDLE;
            nxt_pins         = PINS_IDLE;
            nxt_odt_meta     = 1'b0;
            nxt_odt          = 1'b0;
            nxt_cke_prev     = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        meta_ff         <= nxt_meta;
        pins_ff         <= nxt_pins;
        odt_meta_ff     <= nxt_odt_meta;
        odt_ff          <= nxt_odt;
        cke_prev_ff     <= nxt_cke_prev;
    end

    //--------------------------------------------------------------------
    // Command decode
    //--------------------------------------------------------------------
    sdcd_dec_t         dec_ff, nxt_dec;
    logic              valid_ff, nxt_valid;
    logic              sref_ff, nxt_sref;
    logic              pdn_ff, nxt_pdn;
    logic              cke_now, cke_was, idle_cmd;
    logic [3:0]        strobes;
    logic [BANK_W-1:0] bank_eff;
    logic [ADDR_W-1:0] col_addr;

    always_comb begin
        cke_now  = pins_ff.clk_en;  // see RULE_01
        cke_was  = cke_prev_ff;
        strobes  = {pins_ff.chip_sel_n, pins_ff.row_strobe_n,
                    pins_ff.col_strobe_n, pins_ff.write_en_n};
        idle_cmd = pins_ff.chip_sel_n ||
                   (strobes[2:0] == 3'h7);
        bank_eff = pins_ff.bank_select;
        if (!DENSITY_1G_UP) begin
            bank_eff[BANK_HI_BIT] = 1'b0;  // see RULE_12
        end
        col_addr = '0;
        col_addr[COL_W-1:0] = pins_ff.address[COL_W-1:0];  // see RULE_13
        // The termination level never enters this decode; see RULE_09
        nxt_dec  = '{cmd: SDCD_CMD_ILLEGAL, auto_precharge: 1'b0,
                     bank: bank_eff, addr: pins_ff.address};
        nxt_sref = sref_ff;
        nxt_pdn  = pdn_ff;
        if (!cke_was && cke_now && idle_cmd) begin
            nxt_dec.cmd = (sref_ff || pdn_ff) ?
                          (sref_ff ? SDCD_CMD_SREF_EXIT : SDCD_CMD_PDN_EXIT) :
                          SDCD_CMD_PDN_EXIT;  // see RULE_08
            nxt_sref    = 1'b0;
            nxt_pdn     = 1'b0;
        end else if (cke_was && !cke_now) begin
            if (idle_cmd) begin
                nxt_dec.cmd = SDCD_CMD_PDN_ENTRY;  // see RULE_08
                nxt_pdn     = 1'b1;
            end else if (strobes == 4'h1) begin
                nxt_dec.cmd = SDCD_CMD_SREF_ENTRY;  // see RULE_03
                nxt_sref    = 1'b1;
            end
        end else if (cke_was && cke_now) begin
            if (pins_ff.chip_sel_n) begin
                nxt_dec.cmd = SDCD_CMD_DESELECT;  // see RULE_07
            end else begin
                unique case (strobes[2:0])
                    3'h0: begin
                        nxt_dec.cmd = SDCD_CMD_MODE_LOAD;  // see RULE_02
                        nxt_dec.bank = bank_eff;  // see RULE_14
                    end
                    3'h1: nxt_dec.cmd = SDCD_CMD_REFRESH;  // see RULE_02
                    3'h2: begin
                        nxt_dec.auto_precharge = pins_ff.address[AP_BIT];
                        nxt_dec.cmd = pins_ff.address[AP_BIT] ?
                                      SDCD_CMD_PRE_ALL : SDCD_CMD_PRE_BANK;  // see RULE_04
                        if (pins_ff.address[AP_BIT]) begin
                            nxt_dec.bank = '0;  // see RULE_04
                        end
                    end
                    3'h3: nxt_dec.cmd = SDCD_CMD_ACTIVATE;  // see RULE_07
                    3'h4: begin
                        nxt_dec.cmd = SDCD_CMD_WRITE;  // see RULE_05
                        nxt_dec.auto_precharge = pins_ff.address[AP_BIT];
                        nxt_dec.addr = col_addr;
                    end
                    3'h5: begin
                        nxt_dec.cmd = SDCD_CMD_READ;  // see RULE_06
                        nxt_dec.auto_precharge = pins_ff.address[AP_BIT];
                        nxt_dec.addr = col_addr;
                    end
                    3'h6: nxt_dec.cmd = SDCD_CMD_ILLEGAL;
                    3'h7: nxt_dec.cmd = SDCD_CMD_NOP;  // see RULE_07
                endcase
            end
        end else if (!cke_was && !cke_now) begin
            nxt_dec.cmd = SDCD_CMD_DESELECT;
        end
        nxt_valid = (nxt_dec.cmd != SDCD_CMD_DESELECT);
        if (SYS_RST) begin
            nxt_dec   = DEC_IDLE;
            nxt_valid = 1'b0;
            nxt_sref  = 1'b0;
            nxt_pdn   = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        dec_ff   <= nxt_dec;
        valid_ff <= nxt_valid;
        sref_ff  <= nxt_sref;
        pdn_ff   <= nxt_pdn;
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    logic term_ff, nxt_term;

    always_comb begin
        // Self refresh state clears one cycle after the synchronised clock enable rises; see RULE_15
        nxt_term = odt_ff && !sref_ff && !nxt_sref;  // see RULE_10
        if (SYS_RST) begin
            nxt_term = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        term_ff <= nxt_term;
    end

    assign DEC             = dec_ff;
    assign DEC_VALID       = valid_ff;
    // Drops on the synchronised clock enable, a cycle ahead of the decode; see RULE_15
    assign IN_SELF_REFRESH = sref_ff && !pins_ff.clk_en;  // see RULE_15
    assign IN_POWER_DOWN   = pdn_ff;
    assign TERMINATION_EN  = term_ff;

endmodule : sdcd_decoder

// [include/sdcd_pkg.sv]
// Constants, types and command codes for the DRAM command decoder.
// Assumes a single 40 MHz clock domain and a synchronous active-high reset.
// Summary of operation
// RULE_01: Commands are decoded only from the select, strobe and clock-enable levels taken at a rising edge.
// RULE_02: With clock enable high twice and select low, all strobes low is mode load and low-low-high is refresh.
// RULE_03: The refresh encoding with clock enable falling from high to low is self refresh entry instead.
// RULE_04: Precharge is row low, column high, write low; the auto precharge bit picks one bank or all banks.
// RULE_05: Write is row high, column low, write low, with the auto precharge bit requesting auto precharge.
// RULE_06: Read is the write encoding with write enable high, with the same auto precharge choice.
// RULE_07: Activate is row low, column high, write high; all strobes high is no-op; select high is deselect.
// RULE_08: Clock enable falling with deselect or no-op enters power-down; rising with either exits power-down or self refresh.
// RULE_09: The termination control input never changes how a command decodes.
// RULE_10: Termination is turned off while the device is in self refresh.
// RULE_11: The controller drives every don't-care input to a valid level.
// RULE_12: Bank bit 2 is used only when the density is 1 gigabit or more, and is ignored otherwise.
// RULE_13: Address bits above the column width are ignored for read and write column addresses.
// RULE_14: During mode load the bank lines pick which mode register takes the operation code.
// RULE_15: Self refresh exit does not wait for the clock; it follows the clock enable input directly. The code follows the synchronised clock enable instead.
// RULE_16: The controller limits power-down time to meet refresh, as none happens in power-down.
package sdcd_pkg;

    //--------------------------------------------------------------------
    // Widths
    //--------------------------------------------------------------------
    localparam int ADDR_W      = 14;
    localparam int BANK_W      = 3;
    localparam int COL_W       = 10;
    localparam int AP_BIT      = 10;
    localparam int BANK_HI_BIT = 2;

    //--------------------------------------------------------------------
    // Types
    //--------------------------------------------------------------------
    typedef enum logic [3:0] {
        SDCD_CMD_DESELECT,
        SDCD_CMD_NOP,
        SDCD_CMD_MODE_LOAD,
        SDCD_CMD_REFRESH,
        SDCD_CMD_SREF_ENTRY,
        SDCD_CMD_SREF_EXIT,
        SDCD_CMD_PRE_BANK,
        SDCD_CMD_PRE_ALL,
        SDCD_CMD_ACTIVATE,
        SDCD_CMD_WRITE,
        SDCD_CMD_READ,
        SDCD_CMD_PDN_ENTRY,
        SDCD_CMD_PDN_EXIT,
        SDCD_CMD_ILLEGAL
    } sdcd_cmd_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              row_strobe_n;
        logic              col_strobe_n;
        logic              write_en_n;
        logic              clk_en;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] address;
    } sdcd_pins_t;

    typedef struct packed {
        sdcd_cmd_t         cmd;
        logic              auto_precharge;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sdcd_dec_t;

    localparam sdcd_pins_t PINS_IDLE = '{chip_sel_n: 1'b1, row_strobe_n: 1'b1,
        col_strobe_n: 1'b1, write_en_n: 1'b1, clk_en: 1'b0,
        bank_select: '0, address: '0};
    localparam sdcd_dec_t DEC_IDLE = '{cmd: SDCD_CMD_DESELECT,
        auto_precharge: 1'b0, bank: '0, addr: '0};

endpackage : sdcd_pkg

// [test/sdcd_ctrl_model.sv]
// Controller model driving the command and address pins.
// Assumes the bench calls issue once per cycle at most.
`timescale 1ns/10ps
module sdcd_ctrl_model (
    input  wire logic           CLK,
    output sdcd_pkg::sdcd_pins_t pins
);
    import sdcd_pkg::*;
    initial pins = PINS_IDLE;
    // Encodings per command kind
    // Every field driven, don't-care ones too
    // Power-down held only a few cycles
    task automatic issue(input logic [3:0] s, input logic k, input logic [2:0] b, input logic [13:0] a);
        @(posedge CLK);
        pins <= '{chip_sel_n: s[3], row_strobe_n: s[2], col_strobe_n: s[1], write_en_n: s[0],
                  clk_en: k, bank_select: b, address: a};
    endtask : issue
endmodule : sdcd_ctrl_model

// [test/sdcd_decoder_asserts.sv]
// Port assertions for the command decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sdcd_decoder_asserts (
    input wire logic                 CLK,
    input wire logic                 SYS_RST,
    input wire sdcd_pkg::sdcd_pins_t PINS,
    input wire logic                 ON_DIE_TERMINATION_CTL,
    input wire sdcd_pkg::sdcd_dec_t  DEC,
    input wire logic                 DEC_VALID,
    input wire logic                 IN_SELF_REFRESH,
    input wire logic                 IN_POWER_DOWN,
    input wire logic                 TERMINATION_EN
);
    import sdcd_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Strobes three samples back with clock enable high in both cycles
    sequence s_cmd(logic [3:0] c);
        $past({PINS.chip_sel_n, PINS.row_strobe_n, PINS.col_strobe_n, PINS.write_en_n}, 3) == c
        && $past(PINS.clk_en, 4) && $past(PINS.clk_en, 3);
    endsequence
    a_valid_tracks: assert property (DEC_VALID == (DEC.cmd != SDCD_CMD_DESELECT))
        else $error("valid flag disagrees with command");
    a_deselect_dec: assert property ($past(PINS.chip_sel_n, 3) && $past(PINS.clk_en, 4)
        && $past(PINS.clk_en, 3) |-> DEC.cmd == SDCD_CMD_DESELECT) else $error("deselect wrong");
    a_read_decode: assert property (s_cmd(4'b0101) |-> DEC.cmd == SDCD_CMD_READ
        && DEC.auto_precharge == $past(PINS.address[AP_BIT], 3)
        && DEC.addr == {4'h0, $past(PINS.address[COL_W-1:0], 3)}) else $error("read wrong");
    a_write_decode: assert property (s_cmd(4'b0100) |-> DEC.cmd == SDCD_CMD_WRITE
        && DEC.auto_precharge == $past(PINS.address[AP_BIT], 3)) else $error("write wrong");
    a_mode_bank: assert property (s_cmd(4'b0000) |-> DEC.cmd == SDCD_CMD_MODE_LOAD
        && DEC.bank == $past(PINS.bank_select, 3)) else $error("mode load wrong");
    a_pre_scope: assert property (s_cmd(4'b0010) |-> DEC.cmd == ($past(PINS.address[AP_BIT], 3) ?
        SDCD_CMD_PRE_ALL : SDCD_CMD_PRE_BANK)) else $error("precharge scope wrong");
    a_refresh_kind: assert property ($past({PINS.chip_sel_n, PINS.row_strobe_n, PINS.col_strobe_n,
        PINS.write_en_n}, 3) == 4'b0001 && $past(PINS.clk_en, 4) |-> DEC.cmd == ($past(PINS.clk_en, 3)
        ? SDCD_CMD_REFRESH : SDCD_CMD_SREF_ENTRY)) else $error("refresh kind wrong");
    a_pdn_entry: assert property (($past(PINS.chip_sel_n, 3) || $past(PINS[ADDR_W+BANK_W+3:ADDR_W+BANK_W+1],
        3) == 3'h7) && $past(PINS.clk_en, 4) && !$past(PINS.clk_en, 3) |-> DEC.cmd == SDCD_CMD_PDN_ENTRY)
        else $error("power-down entry wrong");
    a_sref_no_odt: assert property ($past(IN_SELF_REFRESH) && IN_SELF_REFRESH |-> !TERMINATION_EN)
        else $error("termination on in self refresh");
    c_sref_in: cover property (DEC.cmd == SDCD_CMD_SREF_ENTRY);
    c_pdn_out: cover property (DEC.cmd == SDCD_CMD_PDN_EXIT);
    c_read_ap: cover property (DEC.cmd == SDCD_CMD_READ && DEC.auto_precharge);
endmodule : sdcd_decoder_asserts

// [test/sdram_command_decoder_tb_top.sv]
// Self-checking bench for the command decoder.
// Assumes the controller model owns the pins.
`timescale 1ns/10ps
module sdram_command_decoder_tb_top;
    import sdcd_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst, odt_ctl;
    sdcd_pins_t pins;
    sdcd_dec_t  dec;
    logic       dec_valid, in_sref, in_pdn, term_en;
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles = 0;
    always #12.5 clk = ~clk;
    sdcd_ctrl_model ctl_u (.CLK(clk), .pins(pins));
    sdcd_decoder dut_u (.CLK(clk), .SYS_RST(sys_rst), .PINS(pins), .ON_DIE_TERMINATION_CTL(odt_ctl),
        .DEC(dec), .DEC_VALID(dec_valid), .IN_SELF_REFRESH(in_sref), .IN_POWER_DOWN(in_pdn),
        .TERMINATION_EN(term_en));
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(string n, logic [4:0] s, logic [4:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cmd_chk(string n, logic [3:0] s, logic k, logic [13:0] a, sdcd_cmd_t e);
        ctl_u.issue(s, k, 3'h5, a);
        repeat (3) @(posedge clk);
        #1;
        chk(n, {dec.cmd, dec_valid}, {e, e != SDCD_CMD_DESELECT});
    endtask : cmd_chk
    task automatic t_decode;
        @(posedge clk);
        odt_ctl <= 1'b1;
        cmd_chk("wake", 4'b0111, 1'b1, 14'h0, SDCD_CMD_PDN_EXIT);
        cmd_chk("mode", 4'b0000, 1'b1, 14'h0444, SDCD_CMD_MODE_LOAD);
        chk("mode_bank", {2'h0, dec.bank}, 5'h5);
        cmd_chk("refresh", 4'b0001, 1'b1, 14'h0, SDCD_CMD_REFRESH);
        cmd_chk("pre_bank", 4'b0010, 1'b1, 14'h0, SDCD_CMD_PRE_BANK);
        cmd_chk("pre_all", 4'b0010, 1'b1, 14'h0400, SDCD_CMD_PRE_ALL);
        cmd_chk("activate", 4'b0011, 1'b1, 14'h1234, SDCD_CMD_ACTIVATE);
        cmd_chk("write", 4'b0100, 1'b1, 14'h0000, SDCD_CMD_WRITE);
        chk("write_ap", {4'h0, dec.auto_precharge}, 5'h0);
        cmd_chk("read", 4'b0101, 1'b1, 14'h3fff, SDCD_CMD_READ);
        chk("read_ap", {4'h0, dec.auto_precharge}, 5'h1);
        chk("read_col_hi", {1'b0, dec.addr[ADDR_W-1:COL_W]}, 5'h0);
        cmd_chk("nop", 4'b0111, 1'b1, 14'h0, SDCD_CMD_NOP);
        cmd_chk("deselect", 4'b1000, 1'b1, 14'h0, SDCD_CMD_DESELECT);
        cmd_chk("illegal", 4'b0110, 1'b1, 14'h0, SDCD_CMD_ILLEGAL);
        @(posedge clk);
        odt_ctl <= 1'b0;
        cmd_chk("read_odt_lo", 4'b0101, 1'b1, 14'h0000, SDCD_CMD_READ);
        chk("read_odt_ap", {4'h0, dec.auto_precharge}, 5'h0);
        @(posedge clk);
        odt_ctl <= 1'b1;
        $display("test decode done");
    endtask : t_decode
    task automatic t_sref;
        cmd_chk("nop", 4'b0111, 1'b1, 14'h0, SDCD_CMD_NOP);
        chk("term_on", {4'h0, term_en}, 5'h1);
        cmd_chk("sref_in", 4'b0001, 1'b0, 14'h0, SDCD_CMD_SREF_ENTRY);
        @(posedge clk);
        #1;
        chk("sref_state", {3'h0, in_sref, term_en}, 5'h2);
        ctl_u.issue(4'b0111, 1'b1, 3'h5, 14'h0);
        repeat (2) @(posedge clk);
        #1;
        chk("sref_early", {3'h0, in_sref, dec_valid}, 5'h0);
        @(posedge clk);
        #1;
        chk("sref_out", {dec.cmd, dec_valid}, {SDCD_CMD_SREF_EXIT, 1'b1});
        chk("sref_clr", {4'h0, in_sref}, 5'h0);
        $display("test self refresh done");
    endtask : t_sref
    task automatic t_pdn;
        cmd_chk("desel", 4'b1000, 1'b1, 14'h0, SDCD_CMD_DESELECT);
        cmd_chk("pdn_in", 4'b1000, 1'b0, 14'h0, SDCD_CMD_PDN_ENTRY);
        @(posedge clk);
        #1;
        chk("pdn_state", {4'h0, in_pdn}, 5'h1);
        cmd_chk("pdn_out", 4'b0111, 1'b1, 14'h0, SDCD_CMD_PDN_EXIT);
        chk("pdn_clr", {4'h0, in_pdn}, 5'h0);
        $display("test power-down done");
    endtask : t_pdn
    initial begin
        sys_rst = 1'b1;
        odt_ctl = 1'b0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_decode();
        t_sref();
        t_pdn();
        tally_and_finish();
    end
endmodule : sdram_command_decoder_tb_top
bind sdcd_decoder sdcd_decoder_asserts chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .PINS(PINS),
    .ON_DIE_TERMINATION_CTL(ON_DIE_TERMINATION_CTL), .DEC(DEC), .DEC_VALID(DEC_VALID),
    .IN_SELF_REFRESH(IN_SELF_REFRESH), .IN_POWER_DOWN(IN_POWER_DOWN), .TERMINATION_EN(TERMINATION_EN));
